// file: verilog/isf_defs.svh
`ifndef ISF_DEFS_SVH
`define ISF_DEFS_SVH
// register byte offsets
`define ISF_OFF_STATUS1 8'h00
`define ISF_OFF_CTRL    8'h04
`define ISF_OFF_BUF     8'h08
`define ISF_OFF_STATUS2 8'h0C
`define ISF_OFF_IRQ_ST  8'h10
`define ISF_OFF_IRQ_EN  8'h14
`define ISF_OFF_IRQ_CLR 8'h18
// control bits
`define ISF_CTRL_ON   0
`define ISF_CTRL_IRQE 1
`define ISF_CTRL_ACKE 2
// sticky event bits
`define ISF_IRQ_BTF  0
`define ISF_IRQ_OWN_ADDR_MATCH 1
`define ISF_IRQ_SB   2
`define ISF_IRQ_ERR  3
`define ISF_IRQ_HDR  4
// reset values
`define ISF_RST_CTRL   3'h0
`define ISF_RST_BYTE   8'h00
`define ISF_RST_IRQ    5'h00
`define ISF_RST_STATUS 8'h00
`endif

// file: verilog/isf_pkg.sv
`default_nettype none
package isf_pkg;
    typedef logic [7:0] isf_byte_type;
    typedef logic [4:0] isf_irq_type;
    typedef logic [2:0] isf_ctrl_type;
endpackage
`default_nettype wire

// file: verilog/isf_status_flags.sv
// Decided for this implementation: the placing of the registers and the APB slave port.
`include "isf_defs.svh"
`default_nettype none
// Function
// RULE_01 - event_pending rises on any flag event or a successful master address byte
// RULE_02 - error part of event_pending clears on a status_two read; others follow their flag
// RULE_03 - interface off holds event_pending, header_sent, direction, byte_done, match clear
// RULE_04 - status_one is 8-bit read-only, resets to zero, event_pending at bit 7
// RULE_05 - header_sent rises once a 10-bit master header byte has gone out
// RULE_06 - header_sent clears on status_two read then write of second address byte
// RULE_07 - sent_not_received tells direction of finished byte, clears with byte_done
// RULE_08 - sent_not_received also clears on stop seen or arbitration lost
// RULE_09 - busy sets on bus start, clears on bus stop or bus error
// RULE_10 - busy is frozen while interface off; software checks idle before enabling
// RULE_11 - byte_done sets on a good byte, raising interrupt when enabled
// RULE_12 - transmit byte_done after acknowledge pulse; address byte only after address done
// RULE_13 - receive byte_done after acknowledge pulse sent, only with reply pulse enabled
// RULE_14 - byte_done clears on status_one read then matching byte_buffer access
// RULE_15 - bus clock held low while byte_done set
// RULE_16 - own_addr_match sets on own address or general call, interrupting when enabled
// RULE_17 - own_addr_match clears on status_one read; bus clock held low meanwhile
// RULE_18 - status_one read arms; byte_buffer access clears byte_done only when armed
// RULE_19 - interrupt line high while irq_enable and event_pending both set
module isf_status_flags
    import isf_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // two-wire pins
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   scl_out,
    output logic                   scl_oe_n,
    // byte engine events
    input  wire logic              ev_start_sent,
    input  wire logic              ev_header_sent,
    input  wire logic              ev_addr_sent,
    input  wire logic              ev_tx_ack,
    input  wire logic              tx_is_addr,
    input  wire logic              ev_addr_done,
    input  wire logic              ev_rx_ack,
    input  wire logic [7:0]        rx_byte,
    input  wire logic              ev_addr_match,
    input  wire logic              ev_ack_missing,
    input  wire logic              ev_stop_seen,
    input  wire logic              ev_arb_lost,
    input  wire logic              ev_bus_error,
    input  wire logic              role_master,
    // to engine and cpu
    output logic      [7:0]        buf_byte,
    output logic                   irq
);

    generate
        if (ADDR_W < 8)
        begin : g_chk
            $error("isf_status_flags: ADDR_W must be at least 8");
        end
    endgenerate

    isf_ctrl_type ctrl_q;
    isf_byte_type buf_q;
    isf_irq_type  ist_q;
    isf_irq_type  ien_q;
    logic [31:0]  rdata_q;
    logic         ready_q;
    logic         err_resp_q;
    logic         hdr_q, tra_q, busy_q, btf_q, own_addr_match_q, role_q, sb_q;
    logic         err_q, asent_q, armed_q, hdr_arm_q, addr_wait_q;
    logic         irq_q, scl_oe_n_q;
    logic         scl_m_q, scl_s_q, sda_m_q, sda_s_q, sda_p_q;

    logic         on, irqe, acke, evp;
    logic         setup, acc, hit;
    logic [7:0]   a8;
    logic         rd_s1, rd_s2, buf_rd, buf_wr, ctrl_wr, iclr_wr, ien_wr;
    logic         btf_tx, btf_set, btf_clr, err_set, bus_start, bus_stop;
    isf_byte_type status1;
    isf_irq_type  ist_set;

    assign on     = ctrl_q[`ISF_CTRL_ON];
    assign irqe   = ctrl_q[`ISF_CTRL_IRQE];
    assign acke   = ctrl_q[`ISF_CTRL_ACKE];
    assign a8     = paddr[7:0];
    assign setup  = psel & ~penable;
    assign acc    = psel & penable & ready_q;
    assign hit    = (a8 == `ISF_OFF_STATUS1) | (a8 == `ISF_OFF_CTRL) | (a8 == `ISF_OFF_BUF)
                  | (a8 == `ISF_OFF_STATUS2) | (a8 == `ISF_OFF_IRQ_ST)
                  | (a8 == `ISF_OFF_IRQ_EN) | (a8 == `ISF_OFF_IRQ_CLR);
    assign rd_s1   = acc & ~pwrite & (a8 == `ISF_OFF_STATUS1);
    assign rd_s2   = acc & ~pwrite & (a8 == `ISF_OFF_STATUS2);
    assign buf_rd  = acc & ~pwrite & (a8 == `ISF_OFF_BUF);
    assign buf_wr  = acc & pwrite & pstrb[0] & (a8 == `ISF_OFF_BUF);
    assign ctrl_wr = acc & pwrite & pstrb[0] & (a8 == `ISF_OFF_CTRL);
    assign ien_wr  = acc & pwrite & pstrb[0] & (a8 == `ISF_OFF_IRQ_EN);
    assign iclr_wr = acc & pwrite & pstrb[0] & (a8 == `ISF_OFF_IRQ_CLR);

    // flag events
    assign btf_tx  = (ev_tx_ack & ~tx_is_addr) | (ev_addr_done & addr_wait_q); // [RULE_12]
    assign btf_set = on & (btf_tx | (ev_rx_ack & acke)); // [RULE_11] [RULE_13]
    assign btf_clr = armed_q & (tra_q ? buf_wr : buf_rd); // [RULE_14] [RULE_18]
    assign err_set = on & (ev_ack_missing | ev_stop_seen | ev_arb_lost | ev_bus_error);
    assign evp     = btf_q | own_addr_match_q | sb_q | err_q | hdr_q | asent_q; // [RULE_01]
    assign status1 = {evp, hdr_q, tra_q, busy_q, btf_q, own_addr_match_q, role_q, sb_q}; // [RULE_04]

    // bus start and stop, seen on synchronised pins
    assign bus_start = scl_s_q & sda_p_q & ~sda_s_q;
    assign bus_stop  = scl_s_q & ~sda_p_q & sda_s_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            scl_m_q <= scl_in;
            scl_s_q <= scl_m_q;
            sda_m_q <= sda_in;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
        end
    end

    // apb answer: no wait state, data captured in setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ready_q    <= 1'b0;
            err_resp_q <= 1'b0;
            rdata_q    <= 32'h0000_0000;
        end
        else
        begin
            ready_q    <= setup & ~ready_q;
            err_resp_q <= setup & ~ready_q & ~hit;
            if (setup & ~pwrite)
            begin
                unique case (a8)
                    `ISF_OFF_STATUS1: rdata_q <= {24'h00_0000, status1};
                    `ISF_OFF_CTRL:    rdata_q <= {29'h0000_0000, ctrl_q};
                    `ISF_OFF_BUF:     rdata_q <= {24'h00_0000, buf_q};
                    `ISF_OFF_STATUS2: rdata_q <= {31'h0000_0000, err_q};
                    `ISF_OFF_IRQ_ST:  rdata_q <= {27'h000_0000, ist_q};
                    `ISF_OFF_IRQ_EN:  rdata_q <= {27'h000_0000, ien_q};
                    default:          rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= `ISF_RST_CTRL;
            ien_q  <= `ISF_RST_IRQ;
        end
        else
        begin
            if (ctrl_wr)
                ctrl_q <= pwdata[2:0];
            if (ien_wr)
                ien_q <= pwdata[4:0];
        end
    end

    // byte buffer: written by software, loaded on each received byte while on; a software write in that cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            buf_q <= `ISF_RST_BYTE;
        else if (buf_wr)
            buf_q <= pwdata[7:0];
        else if (on & ev_rx_ack)
            buf_q <= rx_byte;
    end

    // clearing sequence arms
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            armed_q   <= 1'b0;
            hdr_arm_q <= 1'b0;
        end
        else
        begin
            if (rd_s1)
                armed_q <= 1'b1; // [RULE_18]
            else if (buf_rd | buf_wr)
                armed_q <= 1'b0; // [RULE_18]
            if (!on)
                hdr_arm_q <= 1'b0;
            else if (rd_s2)
                hdr_arm_q <= 1'b1; // [RULE_06]
            else if (buf_wr)
                hdr_arm_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            addr_wait_q <= 1'b0;
        else if (!on | ev_addr_done)
            addr_wait_q <= 1'b0;
        else if (ev_tx_ack & tx_is_addr)
            addr_wait_q <= 1'b1; // [RULE_12]
    end

    // byte done and direction
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            btf_q <= 1'b0;
            tra_q <= 1'b0;
        end
        else if (!on)
        begin
            btf_q <= 1'b0; // [RULE_03]
            tra_q <= 1'b0; // [RULE_03]
        end
        else if (btf_set)
        begin
            btf_q <= 1'b1; // [RULE_11]
            tra_q <= btf_tx; // [RULE_07]
        end
        else
        begin
            if (btf_clr)
                btf_q <= 1'b0; // [RULE_14]
            if (btf_clr | ev_stop_seen | ev_arb_lost)
                tra_q <= 1'b0; // [RULE_07] [RULE_08]
        end
    end

    // address match, start sent, header sent, errors, address sent
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            own_addr_match_q  <= 1'b0;
            sb_q    <= 1'b0;
            hdr_q   <= 1'b0;
            err_q   <= 1'b0;
            asent_q <= 1'b0;
        end
        else if (!on)
        begin
            own_addr_match_q  <= 1'b0; // [RULE_03]
            sb_q    <= 1'b0;
            hdr_q   <= 1'b0; // [RULE_03]
            err_q   <= 1'b0;
            asent_q <= 1'b0;
        end
        else
        begin
            if (ev_addr_match)
                own_addr_match_q <= 1'b1; // [RULE_16]
            else if (rd_s1)
                own_addr_match_q <= 1'b0; // [RULE_17]
            if (ev_start_sent)
                sb_q <= 1'b1;
            else if (armed_q & buf_wr)
                sb_q <= 1'b0;
            if (ev_header_sent)
                hdr_q <= 1'b1; // [RULE_05]
            else if (hdr_arm_q & buf_wr)
                hdr_q <= 1'b0; // [RULE_06]
            if (err_set)
                err_q <= 1'b1; // [RULE_01]
            else if (rd_s2)
                err_q <= 1'b0; // [RULE_02]
            if (ev_addr_sent)
                asent_q <= 1'b1; // [RULE_01]
            else if (rd_s1)
                asent_q <= 1'b0;
        end
    end

    // busy and role
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_q <= 1'b0;
            role_q <= 1'b0;
        end
        else
        begin
            role_q <= on & role_master;
            if (on)
            begin
                if (bus_start)
                    busy_q <= 1'b1; // [RULE_09] [RULE_10]
                else if (bus_stop | ev_bus_error)
                    busy_q <= 1'b0; // [RULE_09]
            end
        end
    end

    // sticky interrupt status, set wins over clear
    assign ist_set = {on & ev_header_sent, err_set, on & ev_start_sent,
                      on & ev_addr_match, btf_set};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ist_q <= `ISF_RST_IRQ;
        else
            ist_q <= (ist_q & ~(iclr_wr ? pwdata[4:0] : 5'h00)) | ist_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_q      <= 1'b0;
            scl_oe_n_q <= 1'b1;
        end
        else
        begin
            irq_q      <= (irqe & evp) | (|(ist_q & ien_q)); // [RULE_19] [RULE_11] [RULE_16]
            scl_oe_n_q <= ~(btf_q | own_addr_match_q); // [RULE_15] [RULE_17]
        end
    end

    assign prdata   = rdata_q;
    assign pready   = ready_q;
    assign pslverr  = err_resp_q;
    assign scl_out  = 1'b0;
    assign scl_oe_n = scl_oe_n_q;
    assign buf_byte = buf_q;
    assign irq      = irq_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_hdr_clear;
        on && hdr_arm_q && buf_wr && !ev_header_sent;
    endsequence
    sequence s_btf_rx_clear;
        on && armed_q && btf_q && !tra_q && buf_rd && !btf_set;
    endsequence

    property p_evp_on_byte;
        btf_set |=> evp;
    endproperty
    a_evp_on_byte: assert property (p_evp_on_byte) else $error("event_pending missed"); // [RULE_01]

    property p_err_clear;
        on && rd_s2 && !err_set |=> !err_q;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("error pending stuck"); // [RULE_02]

    property p_off_clears;
        !on |=> !(evp || hdr_q || tra_q || btf_q || own_addr_match_q);
    endproperty
    a_off_clears: assert property (p_off_clears) else $error("flag kept while off"); // [RULE_03]

    property p_hdr_clear;
        s_hdr_clear |=> !hdr_q;
    endproperty
    a_hdr_clear: assert property (p_hdr_clear) else $error("header_sent not cleared"); // [RULE_06]

    property p_tra_dir;
        on && btf_set |=> btf_q && (tra_q == $past(btf_tx));
    endproperty
    a_tra_dir: assert property (p_tra_dir) else $error("direction wrong"); // [RULE_07]

    property p_busy_start;
        on && bus_start |=> busy_q;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy not set"); // [RULE_09]

    property p_busy_frozen;
        !on |=> $stable(busy_q);
    endproperty
    a_busy_frozen: assert property (p_busy_frozen) else $error("busy moved while off"); // [RULE_10]

    property p_btf_clear;
        s_btf_rx_clear |=> !btf_q;
    endproperty
    a_btf_clear: assert property (p_btf_clear) else $error("byte_done not cleared"); // [RULE_14]

    property p_unarmed;
        on && btf_q && !armed_q && (buf_rd || buf_wr) |=> btf_q;
    endproperty
    a_unarmed: assert property (p_unarmed) else $error("byte_done cleared unarmed"); // [RULE_18]

    property p_stretch;
        (btf_q || own_addr_match_q) |=> !scl_oe_n;
    endproperty
    a_stretch: assert property (p_stretch) else $error("clock not held low"); // [RULE_15]

    property p_release;
        !(btf_q || own_addr_match_q) |=> scl_oe_n;
    endproperty
    a_release: assert property (p_release) else $error("clock held without cause"); // [RULE_17]

    property p_irq;
        irqe && evp |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised"); // [RULE_19]

endmodule
`default_nettype wire

// file: sim/isf_bus_peer.sv
`default_nettype none
module isf_bus_peer
(
    // resolved clock wire
    input  wire logic scl_wire,
    // open-drain drives, 1 = released to pull-up
    output logic      scl_drv,
    output logic      sda_drv
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end

    // start, then clock pulses at 160 ns, left low mid-frame
    task automatic frame_open(input int pulses);
        #3;
        sda_drv = 1'b0;
        #80;
        repeat (pulses)
        begin
            scl_drv = 1'b0;
            #80;
            scl_drv = 1'b1;
            // a stretched clock holds the high phase back
            wait (scl_wire === 1'b1);
            #80;
        end
        scl_drv = 1'b0;
        #80;
    endtask

    // stop: data rises while clock is high, then idle on pull-ups
    task automatic frame_close();
        sda_drv = 1'b0;
        #80;
        scl_drv = 1'b1;
        #80;
        sda_drv = 1'b1;
    endtask
endmodule
`default_nettype wire

// file: sim/isf_status_flags_tb_top.sv
`include "isf_defs.svh"
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) fail($sformatf("got %h exp %h", g, e)); end
module isf_status_flags_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk, presetn, psel, penable, pwrite, pslverr, pready, irq;
    logic        scl_out, scl_oe_n, scl_drv, sda_drv, scl_wire, rerr, tx_is_addr;
    logic        role_master;
    logic [6:0]  ev;
    // event pulse positions in ev
    localparam int EV_HDR   = 0;
    localparam int EV_TX    = 1;
    localparam int EV_DONE  = 2;
    localparam int EV_RX    = 3;
    localparam int EV_MATCH = 4;
    localparam int EV_START = 5;
    localparam int EV_ASENT = 6;
    logic [3:0]  err_ev;
    logic [7:0]  paddr, rx_byte, buf_byte;
    logic [31:0] pwdata, prdata, rdat;
    int          error_cnt = 0;
    int          cmp_count = 0;

    assign scl_wire = scl_drv & (scl_oe_n | scl_out);

    isf_status_flags u_isf_status_flags (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_in(scl_wire), .sda_in(sda_drv), .scl_out(scl_out),
        .scl_oe_n(scl_oe_n), .ev_start_sent(ev[EV_START]), .ev_header_sent(ev[EV_HDR]),
        .ev_addr_sent(ev[EV_ASENT]), .ev_tx_ack(ev[EV_TX]), .tx_is_addr(tx_is_addr),
        .ev_addr_done(ev[EV_DONE]), .ev_rx_ack(ev[EV_RX]), .rx_byte(rx_byte),
        .ev_addr_match(ev[EV_MATCH]), .ev_ack_missing(err_ev[0]), .ev_stop_seen(err_ev[1]),
        .ev_arb_lost(err_ev[2]), .ev_bus_error(err_ev[3]), .role_master(role_master),
        .buf_byte(buf_byte), .irq(irq));

    isf_bus_peer u_isf_bus_peer (.scl_wire(scl_wire), .scl_drv(scl_drv), .sda_drv(sda_drv));

    always #5 pclk = ~pclk;

    task automatic fail(input string m);
        error_cnt++;
        $display("[ERR] %0t %s", $time, m);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (n >= 16)
            fail("no pready");
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        `CHK(rdat, 32'(e))
    endtask

    task automatic pulse(input int k);
        ev <= 7'(1 << k);
        @(posedge pclk);
        ev <= 7'h00;
        repeat (2) @(posedge pclk);
    endtask

    task automatic reenable(input logic [7:0] c);
        apb(1'b1, `ISF_OFF_CTRL, 8'h00);
        apb(1'b1, `ISF_OFF_CTRL, c);
    endtask

    task automatic t_reset();
        rchk(`ISF_OFF_STATUS1, 8'h00);
        apb(1'b1, `ISF_OFF_STATUS1, 8'hff);
        rchk(`ISF_OFF_STATUS1, 8'h00);
        rchk(8'h1c, 8'h00);
        `CHK(rerr, 1'b1)
        $display("test reset done");
    endtask

    task automatic t_tx();
        apb(1'b1, `ISF_OFF_CTRL, 8'h03);
        pulse(EV_TX);
        rchk(`ISF_OFF_STATUS1, 8'ha8);
        `CHK(scl_oe_n, 1'b0)
        `CHK(irq, 1'b1)
        apb(1'b1, `ISF_OFF_BUF, 8'h3c);
        `CHK(buf_byte, 8'h3c)
        rchk(`ISF_OFF_STATUS1, 8'h00);
        `CHK(scl_oe_n, 1'b1)
        `CHK(irq, 1'b0)
        $display("test tx done");
    endtask

    task automatic t_rx();
        apb(1'b1, `ISF_OFF_CTRL, 8'h05);
        apb(1'b0, `ISF_OFF_BUF, 8'h00);
        rx_byte <= 8'h5a;
        pulse(EV_RX);
        apb(1'b0, `ISF_OFF_BUF, 8'h00);
        rchk(`ISF_OFF_STATUS1, 8'h88);
        rchk(`ISF_OFF_BUF, 8'h5a);
        rchk(`ISF_OFF_STATUS1, 8'h00);
        $display("test rx done");
    endtask

    task automatic t_match();
        pulse(EV_MATCH);
        `CHK(scl_oe_n, 1'b0)
        rchk(`ISF_OFF_STATUS1, 8'h84);
        rchk(`ISF_OFF_STATUS1, 8'h00);
        pulse(EV_MATCH);
        apb(1'b1, `ISF_OFF_CTRL, 8'h00);
        rchk(`ISF_OFF_STATUS1, 8'h00);
        apb(1'b1, `ISF_OFF_CTRL, 8'h05);
        $display("test match done");
    endtask

    task automatic t_header();
        role_master <= 1'b1;
        pulse(EV_HDR);
        rchk(`ISF_OFF_STATUS1, 8'hc2);
        apb(1'b1, `ISF_OFF_BUF, 8'h11);
        rchk(`ISF_OFF_STATUS1, 8'hc2);
        apb(1'b0, `ISF_OFF_STATUS2, 8'h00);
        apb(1'b1, `ISF_OFF_BUF, 8'h22);
        rchk(`ISF_OFF_STATUS1, 8'h02);
        role_master <= 1'b0;
        $display("test header done");
    endtask

    task automatic t_err();
        for (int i = 0; i < 4; i++)
        begin
            err_ev <= 4'(1 << i);
            @(posedge pclk);
            err_ev <= 4'h0;
            repeat (2) @(posedge pclk);
            rchk(`ISF_OFF_STATUS1, 8'h80);
            rchk(`ISF_OFF_STATUS2, 8'h01);
            rchk(`ISF_OFF_STATUS1, 8'h00);
        end
        pulse(EV_TX);
        err_ev <= 4'h4;
        @(posedge pclk);
        err_ev <= 4'h0;
        repeat (2) @(posedge pclk);
        rchk(`ISF_OFF_STATUS1, 8'h88);
        reenable(8'h05);
        $display("test error done");
    endtask

    task automatic t_addr();
        tx_is_addr <= 1'b1;
        pulse(EV_TX);
        apb(1'b0, `ISF_OFF_STATUS1, 8'h00);
        `CHK(rdat[3], 1'b0)
        pulse(EV_DONE);
        apb(1'b0, `ISF_OFF_STATUS1, 8'h00);
        `CHK(rdat[3], 1'b1)
        tx_is_addr <= 1'b0;
        reenable(8'h01);
        $display("test address done");
    endtask

    task automatic t_start();
        pulse(EV_START);
        rchk(`ISF_OFF_STATUS1, 8'h81);
        apb(1'b1, `ISF_OFF_BUF, 8'h00);
        rchk(`ISF_OFF_STATUS1, 8'h00);
        pulse(EV_ASENT);
        rchk(`ISF_OFF_STATUS1, 8'h80);
        rchk(`ISF_OFF_STATUS1, 8'h00);
        $display("test start done");
    endtask

    task automatic t_irq();
        // earlier tests left sticky bits behind
        apb(1'b1, `ISF_OFF_IRQ_CLR, 8'h1f);
        rchk(`ISF_OFF_IRQ_ST, 8'h00);
        apb(1'b1, `ISF_OFF_IRQ_EN, 8'h01);
        pulse(EV_TX);
        `CHK(irq, 1'b1)
        apb(1'b1, `ISF_OFF_IRQ_EN, 8'h00);
        @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(1'b1, `ISF_OFF_IRQ_EN, 8'h01);
        rchk(`ISF_OFF_IRQ_ST, 8'h01);
        `CHK(irq, 1'b1)
        apb(1'b1, `ISF_OFF_IRQ_CLR, 8'h01);
        rchk(`ISF_OFF_IRQ_ST, 8'h00);
        `CHK(irq, 1'b0)
        reenable(8'h01);
        $display("test irq done");
    endtask

    task automatic t_busy();
        u_isf_bus_peer.frame_open(2);
        @(posedge pclk);
        rchk(`ISF_OFF_STATUS1, 8'h10);
        u_isf_bus_peer.frame_close();
        repeat (6) @(posedge pclk);
        rchk(`ISF_OFF_STATUS1, 8'h00);
        apb(1'b1, `ISF_OFF_CTRL, 8'h00);
        u_isf_bus_peer.frame_open(1);
        repeat (6) @(posedge pclk);
        rchk(`ISF_OFF_STATUS1, 8'h00);
        u_isf_bus_peer.frame_close();
        $display("test busy done");
    endtask

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, tx_is_addr, role_master} = '0;
        ev = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        rx_byte = 8'h00;
        err_ev = 4'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_tx();
        t_rx();
        t_match();
        t_header();
        t_err();
        t_addr();
        t_start();
        t_irq();
        t_busy();
        report_and_stop();
    end

    initial
    begin
        #200us;
        fail("watchdog");
        report_and_stop();
    end
endmodule
`default_nettype wire
